// ==== rtl/cmp_wave_consts.svh ====
// constants for the compare output waveform block
`ifndef CMP_WAVE_CONSTS_SVH
`define CMP_WAVE_CONSTS_SVH
// ************************************************************
// register map (word addresses on the bus)
// ************************************************************
`define ADDR_CTRL_A 8'h80
`define ADDR_CTRL_B 8'h81
`define ADDR_CMP_A_LO 8'h88
`define ADDR_CMP_A_HI 8'h89
`define ADDR_CMP_B_LO 8'h8a
`define ADDR_CMP_B_HI 8'h8b
`define ADDR_CAP_LO 8'h86
`define ADDR_CAP_HI 8'h87
`define ADDR_STATUS 8'h90
`define ADDR_MASK 8'h91
`define ADDR_PIN 8'h92
// ************************************************************
// fields and reset values
// ************************************************************
`define ACT_A_HI 7
`define ACT_A_LO 6
`define ACT_B_HI 5
`define ACT_B_LO 4
`define MODE_LO_HI 1
`define MODE_HI_HI 4
`define MODE_HI_LO 3
`define RST_CTRL 8'h00
`define ST_OVF 0
`define ST_MATCH_A 1
`define ST_MATCH_B 2
`define MODE_TOGGLE_FAST_A 4'he
`define MODE_TOGGLE_FAST_B 4'hf
`define MODE_TOGGLE_DUAL_A 4'h9
`define MODE_TOGGLE_DUAL_B 4'hb
`define MAX_COUNT 16'hffff
`endif

// ==== rtl/cmp_wave_pkg.sv ====
// types shared by the compare output waveform block
package cmp_wave_pkg;
  typedef enum logic [1:0] {KIND_NONPWM, KIND_FAST, KIND_DUAL} wave_kind_t;
  typedef enum logic [1:0] {ACT_OFF, ACT_TOGGLE, ACT_CLEAR, ACT_SET} out_action_t;
endpackage : cmp_wave_pkg

// ==== rtl/cmp_out_chan.sv ====
// one compare channel: active compare register, match detect and output latch
`timescale 1ns/1ps
`include "cmp_wave_consts.svh"
module cmp_out_chan #(
  parameter int WIDTH = 16,
  parameter bit IS_A = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] count_value_i,
  input wire logic [WIDTH-1:0] top_i,
  input wire logic count_up_i,
  input wire logic at_zero_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] buf_i,
  input wire logic [1:0] action_i,
  input wire logic [3:0] waveform_mode_i,
  input wire cmp_wave_pkg::wave_kind_t kind_i,
  output logic [WIDTH-1:0] active_o,
  output logic match_o,
  output logic pin_o,
  output logic connected_o
);
  // refuse widths that the 16-bit compare path cannot serve
  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("cmp_out_chan: WIDTH must be 2..16");
  end

  typedef struct packed {
    logic [WIDTH-1:0] active;
    logic pin;
  } state_t;
  state_t q;
  state_t next_q;
  logic hit;
  logic toggle_ok;

  // match and action decode; only the tick qualifies a match
  always_comb begin
    next_q = q;
    hit = tick_i && (count_value_i == q.active);
    toggle_ok = 1'b0;
    case (kind_i)
      cmp_wave_pkg::KIND_FAST: toggle_ok = IS_A && (waveform_mode_i == `MODE_TOGGLE_FAST_A ||
        waveform_mode_i == `MODE_TOGGLE_FAST_B);
      cmp_wave_pkg::KIND_DUAL: toggle_ok = IS_A && (waveform_mode_i == `MODE_TOGGLE_DUAL_A ||
        waveform_mode_i == `MODE_TOGGLE_DUAL_B);
      default: toggle_ok = 1'b1;
    endcase
    connected_o = (action_i != 2'b00) && (action_i != 2'b01 || toggle_ok);
    if (load_i) begin
      next_q.active = buf_i;
    end
    case (kind_i)
      cmp_wave_pkg::KIND_NONPWM: begin
        if (hit) begin
          case (cmp_wave_pkg::out_action_t'(action_i))
            cmp_wave_pkg::ACT_TOGGLE: next_q.pin = ~q.pin;
            cmp_wave_pkg::ACT_CLEAR: next_q.pin = 1'b0;
            cmp_wave_pkg::ACT_SET: next_q.pin = 1'b1;
            default: next_q.pin = q.pin;
          endcase
        end
      end
      cmp_wave_pkg::KIND_FAST: begin
        // a compare equal to top would fight the zero action; the zero action wins
        if (hit && !(action_i[1] && q.active == top_i)) begin
          case (cmp_wave_pkg::out_action_t'(action_i))
            cmp_wave_pkg::ACT_TOGGLE: next_q.pin = toggle_ok ? ~q.pin : q.pin;
            cmp_wave_pkg::ACT_CLEAR: next_q.pin = 1'b0;
            cmp_wave_pkg::ACT_SET: next_q.pin = 1'b1;
            default: next_q.pin = q.pin;
          endcase
        // at_zero_i marks the tick that steps the counter to zero, so the zero action lands with zero itself
        end else if (tick_i && at_zero_i && action_i[1]) begin
          next_q.pin = ~action_i[0];
        end
      end
      cmp_wave_pkg::KIND_DUAL: begin
        if (hit) begin
          case (cmp_wave_pkg::out_action_t'(action_i))
            cmp_wave_pkg::ACT_TOGGLE: next_q.pin = toggle_ok ? ~q.pin : q.pin;
            cmp_wave_pkg::ACT_CLEAR: next_q.pin = ~count_up_i;
            cmp_wave_pkg::ACT_SET: next_q.pin = count_up_i;
            default: next_q.pin = q.pin;
          endcase
        end
      end
      default: next_q = q;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign active_o = q.active;
  assign pin_o = q.pin;
  assign match_o = hit;
endmodule : cmp_out_chan

// ==== rtl/cmp_wave_top.sv ====
// timer with two compare outputs, avalon-mm register slave and interrupt
`timescale 1ns/1ps
`include "cmp_wave_consts.svh"
module cmp_wave_top #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic timer_tick_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic dir_a_out_i,
  input wire logic dir_b_out_i,
  output logic compare_pin_a_o,
  output logic compare_pin_a_oe_n_o,
  output logic compare_pin_b_o,
  output logic compare_pin_b_oe_n_o,
  output logic irq_o
);
  // refuse widths that the byte-wide register map cannot serve
  if (WIDTH != 16) begin : g_width_check
    $error("cmp_wave_top: only a 16-bit counter is supported");
  end

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [1:0] mode_hi;
    logic [15:0] cmp_buf_a;
    logic [15:0] cmp_buf_b;
    logic [15:0] cap;
    logic [15:0] count_value;
    logic count_up;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic ack;
    logic pin_a;
    logic pin_b;
    logic oe_a_n;
    logic oe_b_n;
    logic irq;
  } state_t;
  state_t q;
  state_t next_q;

  logic [3:0] waveform_mode;
  cmp_wave_pkg::wave_kind_t kind;
  logic [15:0] top;
  logic [15:0] act_a;
  logic [15:0] act_b;
  logic match_a;
  logic match_b;
  logic ch_pin_a;
  logic ch_pin_b;
  logic con_a;
  logic con_b;
  logic at_zero;
  logic at_top;
  logic load;
  logic ovf_ev;
  logic access;
  logic [15:0] fixed_top;

  // ************************************************************
  // mode decode
  // ************************************************************
  always_comb begin
    waveform_mode = {q.mode_hi, q.ctrl_a[`MODE_LO_HI:0]};
    case (waveform_mode[1:0])
      2'b01: fixed_top = 16'h00ff;
      2'b10: fixed_top = 16'h01ff;
      default: fixed_top = 16'h03ff;
    endcase
    kind = cmp_wave_pkg::KIND_NONPWM;
    top = `MAX_COUNT;
    case (waveform_mode)
      4'h0: top = `MAX_COUNT;
      4'h4: top = act_a;
      4'hc: top = q.cap;
      4'h1, 4'h2, 4'h3: begin
        kind = cmp_wave_pkg::KIND_DUAL;
        top = fixed_top;
      end
      4'h5, 4'h6, 4'h7: begin
        kind = cmp_wave_pkg::KIND_FAST;
        top = fixed_top;
      end
      4'h8, 4'ha: begin
        kind = cmp_wave_pkg::KIND_DUAL;
        top = q.cap;
      end
      4'h9, 4'hb: begin
        kind = cmp_wave_pkg::KIND_DUAL;
        top = act_a;
      end
      4'he: begin
        kind = cmp_wave_pkg::KIND_FAST;
        top = q.cap;
      end
      4'hf: begin
        kind = cmp_wave_pkg::KIND_FAST;
        top = act_a;
      end
      default: top = `MAX_COUNT;
    endcase
    at_zero = (q.count_value == 16'h0000);
    at_top = (q.count_value == top);
    // buffer load point: immediate in non-pwm, zero in fast and freq-correct, top in phase-correct
    case (waveform_mode)
      4'h8, 4'h9: load = timer_tick_i && at_zero;
      4'h1, 4'h2, 4'h3, 4'ha, 4'hb: load = timer_tick_i && at_top;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: load = timer_tick_i && at_top; // reload as counter wraps to zero
      default: load = 1'b1;
    endcase
    // overflow on the tick in which the counter sits at the documented point
    case (kind)
      cmp_wave_pkg::KIND_DUAL: ovf_ev = timer_tick_i && at_zero;
      cmp_wave_pkg::KIND_FAST: ovf_ev = timer_tick_i && at_top;
      default: ovf_ev = timer_tick_i && q.count_value == `MAX_COUNT;
    endcase
  end

  // ************************************************************
  // compare channels
  // ************************************************************
  cmp_out_chan #(.WIDTH(16), .IS_A(1'b1)) u_chan_a (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .tick_i(timer_tick_i),
    .count_value_i(q.count_value),
    .top_i(top),
    .count_up_i(q.count_up),
    .at_zero_i(at_top), // single-slope counter reaches zero on the tick that finds it at top
    .load_i(load),
    .buf_i(q.cmp_buf_a),
    .action_i(q.ctrl_a[`ACT_A_HI:`ACT_A_LO]),
    .waveform_mode_i(waveform_mode),
    .kind_i(kind),
    .active_o(act_a),
    .match_o(match_a),
    .pin_o(ch_pin_a),
    .connected_o(con_a)
  );

  cmp_out_chan #(.WIDTH(16), .IS_A(1'b0)) u_chan_b (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .tick_i(timer_tick_i),
    .count_value_i(q.count_value),
    .top_i(top),
    .count_up_i(q.count_up),
    .at_zero_i(at_top),
    .load_i(load),
    .buf_i(q.cmp_buf_b),
    .action_i(q.ctrl_a[`ACT_B_HI:`ACT_B_LO]),
    .waveform_mode_i(waveform_mode),
    .kind_i(kind),
    .active_o(act_b),
    .match_o(match_b),
    .pin_o(ch_pin_b),
    .connected_o(con_b)
  );

  // ************************************************************
  // counter, bus slave, status and pins
  // ************************************************************
  always_comb begin
    next_q = q;
    access = (read_i || write_i) && !q.ack;
    next_q.ack = access;
    // counter steps only on the tick
    if (timer_tick_i) begin
      if (kind == cmp_wave_pkg::KIND_DUAL) begin
        if (q.count_up && at_top) begin
          next_q.count_up = 1'b0;
          next_q.count_value = q.count_value - 16'h0001;
        end else if (!q.count_up && at_zero) begin
          next_q.count_up = 1'b1;
          next_q.count_value = 16'h0001;
        end else begin
          next_q.count_value = q.count_up ? q.count_value + 16'h0001 : q.count_value - 16'h0001;
        end
      end else begin
        next_q.count_up = 1'b1;
        next_q.count_value = at_top ? 16'h0000 : q.count_value + 16'h0001;
      end
    end
    // sticky events; a read clears, but a same-cycle event survives
    if (access && read_i && address_i == `ADDR_STATUS) begin
      next_q.status = 3'b000;
    end
    if (ovf_ev) next_q.status[`ST_OVF] = 1'b1;
    if (match_a) next_q.status[`ST_MATCH_A] = 1'b1;
    if (match_b) next_q.status[`ST_MATCH_B] = 1'b1;
    next_q.rdata = 32'h0000_0000;
    if (access && write_i) begin
      case (address_i)
        `ADDR_CTRL_A: next_q.ctrl_a = {writedata_i[7:4], 2'b00, writedata_i[1:0]};
        `ADDR_CTRL_B: next_q.mode_hi = writedata_i[`MODE_HI_HI:`MODE_HI_LO];
        `ADDR_CMP_A_LO: next_q.cmp_buf_a[7:0] = writedata_i[7:0];
        `ADDR_CMP_A_HI: next_q.cmp_buf_a[15:8] = writedata_i[7:0];
        `ADDR_CMP_B_LO: next_q.cmp_buf_b[7:0] = writedata_i[7:0];
        `ADDR_CMP_B_HI: next_q.cmp_buf_b[15:8] = writedata_i[7:0];
        `ADDR_CAP_LO: next_q.cap[7:0] = writedata_i[7:0];
        `ADDR_CAP_HI: next_q.cap[15:8] = writedata_i[7:0];
        `ADDR_MASK: next_q.mask = writedata_i[2:0];
        default: next_q.mask = q.mask;
      endcase
    end else if (access && read_i) begin
      case (address_i)
        `ADDR_CTRL_A: next_q.rdata = {24'h000000, q.ctrl_a};
        `ADDR_CTRL_B: next_q.rdata = {27'h000000, q.mode_hi, 3'b000};
        `ADDR_CMP_A_LO: next_q.rdata = {24'h000000, q.cmp_buf_a[7:0]};
        `ADDR_CMP_A_HI: next_q.rdata = {24'h000000, q.cmp_buf_a[15:8]};
        `ADDR_CMP_B_LO: next_q.rdata = {24'h000000, q.cmp_buf_b[7:0]};
        `ADDR_CMP_B_HI: next_q.rdata = {24'h000000, q.cmp_buf_b[15:8]};
        `ADDR_CAP_LO: next_q.rdata = {24'h000000, q.cap[7:0]};
        `ADDR_CAP_HI: next_q.rdata = {24'h000000, q.cap[15:8]};
        `ADDR_STATUS: next_q.rdata = {29'h0000000, q.status};
        `ADDR_MASK: next_q.rdata = {29'h0000000, q.mask};
        `ADDR_PIN: next_q.rdata = {30'h0000000, ch_pin_b, ch_pin_a};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
    // pins follow the channel latch, driven only when direction is output
    next_q.pin_a = con_a ? ch_pin_a : 1'b0;
    next_q.pin_b = con_b ? ch_pin_b : 1'b0;
    next_q.oe_a_n = !(con_a && dir_a_out_i);
    next_q.oe_b_n = !(con_b && dir_b_out_i);
    next_q.irq = |(next_q.status & q.mask);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.oe_a_n <= 1'b1;
      q.oe_b_n <= 1'b1;
      q.count_up <= 1'b1;
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  assign readdata_o = q.rdata;
  assign waitrequest_o = !q.ack;
  assign compare_pin_a_o = q.pin_a;
  assign compare_pin_b_o = q.pin_b;
  assign compare_pin_a_oe_n_o = q.oe_a_n;
  assign compare_pin_b_oe_n_o = q.oe_b_n;
  assign irq_o = q.irq;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_drv_dir;
    @(posedge clk_sys_i) disable iff (!arst_n_i) ce_i && !dir_a_out_i |=> compare_pin_a_oe_n_o;
  endproperty
  a_drv_dir: assert property (p_drv_dir) else $error("pin a driven without output direction");
  property p_off_disc;
    @(posedge clk_sys_i) disable iff (!arst_n_i) ce_i && q.ctrl_a[7:6] == 2'b00 |=> compare_pin_a_oe_n_o;
  endproperty
  a_off_disc: assert property (p_off_disc) else $error("pin a connected with action zero");
  property p_b_dual_toggle;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && kind == cmp_wave_pkg::KIND_DUAL && q.ctrl_a[5:4] == 2'b01 |=> compare_pin_b_oe_n_o;
  endproperty
  a_b_dual_toggle: assert property (p_b_dual_toggle) else $error("pin b connected in toggle");
  property p_fast_clr;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && kind == cmp_wave_pkg::KIND_FAST && q.ctrl_a[7:6] == 2'b10 && match_a && act_a != top |=> !ch_pin_a;
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("fast pwm clear missed");
  property p_fast_set;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && kind == cmp_wave_pkg::KIND_FAST && q.ctrl_a[7:6] == 2'b11 && match_a && act_a != top |=> ch_pin_a;
  endproperty
  a_fast_set: assert property (p_fast_set) else $error("fast pwm set missed");
  property p_zero_act;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && kind == cmp_wave_pkg::KIND_FAST && q.ctrl_a[7:6] == 2'b10 && timer_tick_i && at_top |=> ch_pin_a;
  endproperty
  a_zero_act: assert property (p_zero_act) else $error("zero action missed");
  property p_dual_up;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && kind == cmp_wave_pkg::KIND_DUAL && q.ctrl_a[7:6] == 2'b10 && match_a |=> ch_pin_a == !$past(q.count_up);
  endproperty
  a_dual_up: assert property (p_dual_up) else $error("dual slope pin wrong");
  property p_match_tick;
    @(posedge clk_sys_i) disable iff (!arst_n_i) !timer_tick_i |=> $stable(ch_pin_a);
  endproperty
  a_match_tick: assert property (p_match_tick) else $error("pin a moved without tick");
  property p_irq;
    @(posedge clk_sys_i) disable iff (!arst_n_i) ce_i && ovf_ev && q.mask[0] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow interrupt missed");
  c_match_a: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) match_a && kind == cmp_wave_pkg::KIND_FAST);
  c_dual: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) match_b && kind == cmp_wave_pkg::KIND_DUAL);
  c_irq: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) irq_o);
endmodule : cmp_wave_top

// ==== bench/pin_port_model.sv ====
// general purpose pin with its direction bit, the far side of one compare output
`timescale 1ns/1ps
module pin_port_model (
  input wire logic dir_i,
  input wire logic port_data_i,
  input wire logic oc_i,
  input wire logic oc_oe_n_i,
  output logic dir_out_o,
  output logic level_o
);
  // direction bit goes straight to the timer, which must gate its own driver with it
  assign dir_out_o = dir_i;
  // compare output wins while driving, else the port data, else the pull-up holds the pad high
  assign level_o = !oc_oe_n_i ? oc_i : (dir_i ? port_data_i : 1'b1);
endmodule : pin_port_model

// ==== bench/tb.sv ====
// self-checking bench for the compare output waveform block
`timescale 1ns/1ps
`include "cmp_wave_consts.svh"
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic tick = 1'b0;
  logic [7:0] address = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic waitreq;
  logic dir_a = 1'b1;
  logic dir_b = 1'b1;
  logic dir_a_pin, dir_b_pin, pin_a, pin_b, oe_a, oe_b, irq, lvl_a, lvl_b;
  integer seed = 32'ha0d8;
  int n_mismatch = 0;
  int check_count = 0;

  always #5 clk = ~clk;

  cmp_wave_top cmp_wave_top_i (.clk_sys_i(clk), .arst_n_i(arst_n), .ce_i(ce), .timer_tick_i(tick),
    .address_i(address), .read_i(rd), .write_i(wr), .writedata_i(wdata), .readdata_o(rdata),
    .waitrequest_o(waitreq), .dir_a_out_i(dir_a_pin), .dir_b_out_i(dir_b_pin), .compare_pin_a_o(pin_a),
    .compare_pin_a_oe_n_o(oe_a), .compare_pin_b_o(pin_b), .compare_pin_b_oe_n_o(oe_b), .irq_o(irq));
  pin_port_model pin_port_model_i (.dir_i(dir_a), .port_data_i(1'b0), .oc_i(pin_a), .oc_oe_n_i(oe_a),
    .dir_out_o(dir_a_pin), .level_o(lvl_a));
  pin_port_model pin_port_b_i (.dir_i(dir_b), .port_data_i(1'b0), .oc_i(pin_b), .oc_oe_n_i(oe_b),
    .dir_out_o(dir_b_pin), .level_o(lvl_b));

  // ************************************************************
  // checking, bus and setup tasks
  // ************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // one avalon access; a clock edge passes first so strobes never change twice in one step
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    wdata <= {24'h000000, d};
    wr <= is_wr;
    rd <= !is_wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    // waitrequest and read data are taken as they stood at this rising edge
    if (waitreq !== 1'b0) begin
      n_mismatch++;
      $display("MISMATCH t=%0t bus access never answered", $time);
      report_and_stop();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrb

  task automatic reset_dut();
    @(posedge clk);
    arst_n <= 1'b0;
    tick <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
  endtask : reset_dut

  // values are written with the tick stopped so the counter starts from zero in the new mode
  task automatic setup(input logic [3:0] mode, input logic [1:0] aa, input logic [1:0] ab,
                       input logic [15:0] top, input logic [15:0] ca, input logic [15:0] cb);
    reset_dut();
    wrb(`ADDR_CAP_LO, top[7:0]);
    wrb(`ADDR_CAP_HI, top[15:8]);
    wrb(`ADDR_CMP_A_LO, ca[7:0]);
    wrb(`ADDR_CMP_A_HI, ca[15:8]);
    wrb(`ADDR_CMP_B_LO, cb[7:0]);
    wrb(`ADDR_CMP_B_HI, cb[15:8]);
    wrb(`ADDR_CTRL_B, {3'b000, mode[3:2], 3'b000});
    wrb(`ADDR_CTRL_A, {aa, ab, 2'b00, mode[1:0]});
  endtask : setup

  // counts high cycles of each pad, sampled away from the active edge
  task automatic measure(input int cycles, output int ha, output int hb);
    ha = 0;
    hb = 0;
    repeat (cycles) begin
      @(negedge clk);
      ha += int'(lvl_a === 1'b1);
      hb += int'(lvl_b === 1'b1);
    end
  endtask : measure

  // high cycles in one pwm period; compare equal to top is handled for the single-slope case only, the bench skips it for dual slope
  function automatic int exp_high(input bit dual, input int act, input int t, input int c);
    if (dual) return (act == 2) ? 2 * c : 2 * (t - c);
    if (act == 2) return (c == t) ? t + 1 : c + 1;
    return (c == t) ? 0 : t - c;
  endfunction : exp_high

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] q;
    int ha, hb, t, ca, cb, aa, per;
    logic [3:0] mode;
    bit dual;
    reset_dut();
    bus(1'b0, `ADDR_CTRL_A, 8'h00, q);
    check(q, {24'h000000, `RST_CTRL}, "control reset value");
    wrb(`ADDR_CTRL_A, 8'hff);
    bus(1'b0, `ADDR_CTRL_A, 8'h00, q);
    check(q, 32'h000000f3, "control readback");
    bus(1'b0, 8'h00, 8'h00, q);
    check(q, 32'h00000000, "unmapped read");
    // clear-on-match mode, period of ten ticks, every action value on channel a
    for (int act = 0; act < 4; act++) begin
      setup(4'h4, 2'(act), 2'b00, 16'h0000, 16'h0009, 16'h0000);
      tick <= 1'b1;
      repeat (30) @(posedge clk);
      measure(20, ha, hb);
      check(ha, (act == 1) ? 10 : (act == 3) ? 20 : 0, "non-pwm high count");
      check(oe_a, (act == 0) ? 32'h1 : 32'h0, "pin taken over");
      check(oe_b, 32'h1, "idle channel b released");
    end
    @(posedge clk);
    dir_a <= 1'b0;
    repeat (3) @(posedge clk);
    check(oe_a, 32'h1, "driver off for input pin");
    check(lvl_a, 32'h1, "pad left to pull-up");
    dir_a <= 1'b1;
    // no tick, no match; then a random tick on about half the cycles must still reach the match
    setup(4'h4, 2'b11, 2'b00, 16'h0000, 16'h0009, 16'h0000);
    repeat (40) @(posedge clk);
    check(lvl_a, 32'h0, "no match without tick");
    // a low clock enable freezes the counter even while the tick runs
    ce <= 1'b0;
    tick <= 1'b1;
    repeat (30) @(posedge clk);
    check(lvl_a, 32'h0, "frozen while enable low");
    ce <= 1'b1;
    tick <= 1'b0;
    repeat (100) @(posedge clk) tick <= 1'($random(seed));
    tick <= 1'b0;
    repeat (3) @(posedge clk);
    check(lvl_a, 32'h1, "match with tick");
    check(irq, 32'h0, "masked interrupt");
    wrb(`ADDR_MASK, 8'h02);
    repeat (3) @(posedge clk);
    check(irq, 32'h1, "unmasked match interrupt");
    bus(1'b0, `ADDR_STATUS, 8'h00, q);
    check(q & 32'h2, 32'h2, "match flag seen");
    repeat (3) @(posedge clk);
    check(irq, 32'h0, "interrupt gone after read");
    bus(1'b0, `ADDR_STATUS, 8'h00, q);
    check(q, 32'h0, "status cleared by read");
    // in pwm, toggle action only connects channel a in the two toggle-capable modes of each family
    for (int i = 0; i < 4; i++) begin
      mode = (i == 0) ? 4'h5 : (i == 1) ? `MODE_TOGGLE_FAST_A : (i == 2) ? 4'h8 : `MODE_TOGGLE_DUAL_A;
      setup(mode, 2'b01, 2'b01, 16'd20, 16'd20, 16'd5);
      repeat (3) @(posedge clk);
      check(oe_a, (i % 2 == 1) ? 32'h0 : 32'h1, "toggle connect a");
      check(oe_b, 32'h1, "toggle keeps b off");
    end
    // random pwm periods and duties; modes 15 and 9 take top from channel a's compare
    for (int i = 0; i < 8; i++) begin
      mode = (i % 4 == 0) ? 4'he : (i % 4 == 1) ? 4'hf : (i % 4 == 2) ? 4'h8 : 4'h9;
      dual = (i % 4 >= 2);
      t = 12 + ({$random(seed)} % 20);
      cb = 1 + ({$random(seed)} % (t - 1));
      ca = (i % 2 == 1) ? t : 1 + ({$random(seed)} % (t - 1));
      aa = 2 + ({$random(seed)} % 2);
      per = dual ? 2 * t : t + 1;
      setup(mode, 2'(aa), 2'(5 - aa), 16'(t), 16'(ca), 16'(cb));
      wrb(`ADDR_MASK, 8'h01);
      tick <= 1'b1;
      repeat (3 * per + 4) @(posedge clk);
      measure(2 * per, ha, hb);
      if (!(dual && ca == t)) check(ha, 2 * exp_high(dual, aa, t, ca), "pwm a");
      check(hb, 2 * exp_high(dual, 5 - aa, t, cb), "pwm b");
      check(irq, 32'h1, "overflow interrupt");
      bus(1'b0, `ADDR_STATUS, 8'h00, q);
      check(q & 32'h1, 32'h1, "overflow flag seen");
    end
    report_and_stop();
  end
endmodule : tb
